/* File: logic/dco_loop_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef DCO_LOOP_MAP_SVH
`define DCO_LOOP_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_MULT 8'h04
`define OFS_TRIM 8'h08
`define OFS_DIV 8'h0C
`define OFS_STG 8'h10

// ----------------------------------------
// control register bit positions
// ----------------------------------------
`define BIT_EXT_STABLE 0
`define BIT_EXT_ON 1
`define BIT_INT_STABLE 2
`define BIT_INT_ON 3
`define BIT_SELECT 4
`define BIT_MON_EN 5
`define BIT_MON_FAIL 6
`define BIT_MON_IRQ_EN 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_MULT 7'h15
`define RST_TRIM 8'h80
`define RST_DIV 4'h0
`define RST_STG 8'h00

// ----------------------------------------
// oscillator and loop figures
// ----------------------------------------
`define RING_MIN_DELAYS 6'h11
`define RING_LONG_MAX 6'h22
`define DIV_MAX_CODE 4'h9
`define REF_PER_CORR 2'h3
`define COARSE_STEP 12'h020
`define FINE_STEP 12'h001
`define COARSE_PCT 16'h000F
`define STABLE_PCT 16'h0005
`define MON_TIMEOUT_DEF 40000

`endif

/* File: logic/dco_loop_pkg.sv */
// shared types of the oscillator loop and clock monitor
package dco_loop_pkg;
  // loop filter sequencing
  typedef enum logic [1:0] {
    LF_HALT,
    LF_ALIGN,
    LF_MEASURE
  } loop_state_type;
endpackage

/* File: logic/dco_loop_and_clock_monitor.sv */
// oscillator, loop filter, clock monitor and wishbone registers
//
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dco_loop_map.svh"

// Summary of operation
// - dead selected source: switch to live one
// - control read with flag set arms clear
// - period set only by stage and divider
// - divider divides by two to code, max 512
// - divider moves only on stage carry/borrow
// - upper stage bits give 17..31 delays
// - lower stage bits dither longer cycles per 32
// - code 111 long point is 17 doubled
// - coarse step above 15 percent, else fine
// - lock internal clock to N times reference
// - correction spans four reference periods
// - factor change may fake dead clock
// - monitor enable refused until internal stable
// - no interlock on frequency changes
// - resettle after reset, factor, trim, restart
// - reset selects internal clock
// - select write needs target on and stable
// - monitor needs both clocks; irq needs monitor
module dco_loop_and_clock_monitor
  import dco_loop_pkg::*;
#(
  parameter int MON_TIMEOUT_CYC = `MON_TIMEOUT_DEF
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  // reference and external oscillator activity
  input wire logic i_ref_tick,
  input wire logic i_ext_clk_tick,
  input wire logic i_ext_stable,
  // clock status outputs
  output logic o_internal_clock,
  output logic o_clock_select,
  output logic o_internal_stable,
  output logic o_monitor_irq,
  output logic [3:0] o_divider_field,
  output logic [7:0] o_stage_field
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // codes above nine act as nine
  function automatic logic [3:0] div_eff(input logic [3:0] d);
    div_eff = (d > `DIV_MAX_CODE) ? `DIV_MAX_CODE : d;
  endfunction

  // ring length in stage delays for a stage code and dither point
  function automatic logic [5:0] ring_len(input logic [2:0] hi, input logic lng);
    logic [5:0] base;
    base = `RING_MIN_DELAYS + {2'b00, hi, 1'b0};
    if (!lng) ring_len = base;
    else if (hi == 3'h7) ring_len = `RING_LONG_MAX;
    else ring_len = base + 6'h02;
  endfunction

  // ----------------------------------------
  // state declarations
  // ----------------------------------------
  logic mon_irq_en_reg; // monitor_irq_enable
  logic mon_fail_reg; // monitor_fail_flag
  logic mon_en_reg; // monitor_enable
  logic select_reg; // 0 internal, 1 external
  logic int_on_reg; // internal_gen_on
  logic int_stable_reg; // internal_stable_flag
  logic ext_on_reg; // external_gen_on
  logic ext_stable_reg; // external_stable_flag
  logic fail_armed_reg; // clear sequence started
  logic [6:0] mult_reg; // multiply factor N
  logic [7:0] trim_reg; // trim value
  logic [11:0] val_reg; // {divider_field, stage_field}
  logic [31:0] rdat_reg; // read data
  logic ack_reg; // bus acknowledge
  logic restart_req; // loop must resettle
  loop_state_type lf_state_reg; // loop filter state
  logic [1:0] ref_cnt_reg; // reference periods in interval
  logic [9:0] icnt_reg; // internal clock periods counted
  logic [5:0] ring_cnt_reg; // stage delays in ring cycle
  logic [4:0] dith_cnt_reg; // ring cycle index out of 32
  logic [9:0] div_cnt_reg; // ring cycles in output period
  logic osc_tick_reg; // one pulse per internal period
  logic [15:0] int_idle_reg; // cycles since internal activity
  logic [15:0] ext_idle_reg; // cycles since external activity
  logic ioff; // internal source looks dead
  logic eoff; // external source looks dead

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire logic req = i_wb_cyc & i_wb_stb & ~ack_reg;
  // write lands at the edge where ack is seen high
  wire logic wr = ack_reg & i_wb_cyc & i_wb_stb & i_wb_we & i_wb_sel[0];
  wire logic wr_ctrl = wr & (i_wb_adr == `OFS_CTRL);
  wire logic wr_mult = wr & (i_wb_adr == `OFS_MULT);
  wire logic wr_trim = wr & (i_wb_adr == `OFS_TRIM);
  wire logic [7:0] wd = i_wb_dat[7:0];
  wire logic [7:0] ctrl_view = {mon_irq_en_reg, mon_fail_reg, mon_en_reg, select_reg,
                                int_on_reg, int_stable_reg, ext_on_reg, ext_stable_reg};

  // acknowledge one cycle after the request; unmapped reads give zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else if (i_ce) begin
      ack_reg <= req;
      if (req) begin
        unique case (i_wb_adr)
          `OFS_CTRL: rdat_reg <= {24'h000000, ctrl_view};
          `OFS_MULT: rdat_reg <= {25'h0000000, mult_reg};
          `OFS_TRIM: rdat_reg <= {24'h000000, trim_reg};
          `OFS_DIV: rdat_reg <= {28'h0000000, val_reg[11:8]};
          `OFS_STG: rdat_reg <= {24'h000000, val_reg[7:0]};
          default: rdat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // source selection and generator enables
  // ----------------------------------------
  // no hardware interlock keeps the bus frequency steady here
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      select_reg <= 1'b0;
      int_on_reg <= 1'b1;
      ext_on_reg <= 1'b0;
      ext_stable_reg <= 1'b0;
    end else if (i_ce) begin
      ext_stable_reg <= ext_on_reg & i_ext_stable;
      if (mon_en_reg && !select_reg && ioff && !eoff) begin
        select_reg <= 1'b1;
      end else if (mon_en_reg && select_reg && eoff && !ioff) begin
        select_reg <= 1'b0;
      end else if (wr_ctrl) begin
        // target must be on and stable before the select moves
        if (wd[`BIT_SELECT] && ext_on_reg && ext_stable_reg) select_reg <= 1'b1;
        if (!wd[`BIT_SELECT] && int_on_reg && int_stable_reg) select_reg <= 1'b0;
      end
      if (wr_ctrl) begin
        // the generator selected before this write cannot be switched off
        int_on_reg <= wd[`BIT_INT_ON] | ~select_reg;
        ext_on_reg <= wd[`BIT_EXT_ON] | select_reg;
      end
    end
  end

  // ----------------------------------------
  // monitor enable and interrupt enable
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mon_en_reg <= 1'b0;
      mon_irq_en_reg <= 1'b0;
    end else if (i_ce && wr_ctrl) begin
      // internal stable must be back before enable sticks
      mon_en_reg <= wd[`BIT_MON_EN] & int_on_reg & int_stable_reg
                    & ext_on_reg & ext_stable_reg;
      mon_irq_en_reg <= wd[`BIT_MON_IRQ_EN] & mon_en_reg;
    end
  end

  // ----------------------------------------
  // monitor fail flag with read-then-write clear
  // ----------------------------------------
  // a bit set/clear on the control register would write the flag as
  // read, so a pending clear could fire by accident
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mon_fail_reg <= 1'b0;
      fail_armed_reg <= 1'b0;
    end else if (i_ce) begin
      if (req && !i_wb_we && (i_wb_adr == `OFS_CTRL) && mon_fail_reg) begin
        fail_armed_reg <= 1'b1;
      end else if (wr_ctrl) begin
        fail_armed_reg <= 1'b0;
      end
      // a new failure wins over the clear
      if (mon_en_reg && (ioff || eoff)) begin
        mon_fail_reg <= 1'b1;
      end else if (wr_ctrl && fail_armed_reg && !wd[`BIT_MON_FAIL]) begin
        mon_fail_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // activity watchdogs
  // ----------------------------------------
  // the internal period shifts while the loop chases a new factor,
  // so software keeps the monitor off then
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_idle_reg <= 16'h0000;
      ext_idle_reg <= 16'h0000;
    end else if (i_ce) begin
      if (osc_tick_reg || !int_on_reg) int_idle_reg <= 16'h0000;
      else if (!ioff) int_idle_reg <= int_idle_reg + 16'h0001;
      if (i_ext_clk_tick || !ext_on_reg) ext_idle_reg <= 16'h0000;
      else if (!eoff) ext_idle_reg <= ext_idle_reg + 16'h0001;
    end
  end
  assign ioff = (int_idle_reg >= 16'(MON_TIMEOUT_CYC));
  assign eoff = (ext_idle_reg >= 16'(MON_TIMEOUT_CYC));

  // ----------------------------------------
  // multiply factor and trim
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mult_reg <= `RST_MULT;
      trim_reg <= `RST_TRIM;
    end else if (i_ce) begin
      if (wr_mult) mult_reg <= wd[6:0];
      if (wr_trim) trim_reg <= wd;
    end
  end

  // resettle on factor or trim change and on generator restart
  assign restart_req = (wr_mult && (wd[6:0] != mult_reg)) || (wr_trim && (wd != trim_reg))
                       || !int_on_reg;

  // ----------------------------------------
  // digital oscillator model, one stage delay per clock
  // ----------------------------------------
  // the period depends only on the stage and divider fields
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ring_cnt_reg <= 6'h00;
      dith_cnt_reg <= 5'h00;
      div_cnt_reg <= 10'h000;
      osc_tick_reg <= 1'b0;
    end else if (i_ce) begin
      osc_tick_reg <= 1'b0;
      if (!int_on_reg) begin
        // restart from the written fields on re-enable
        ring_cnt_reg <= 6'h00;
        dith_cnt_reg <= 5'h00;
        div_cnt_reg <= 10'h000;
      end else if (ring_cnt_reg >= ring_len(val_reg[7:5],
                   dith_cnt_reg < val_reg[4:0]) - 6'h01) begin
        ring_cnt_reg <= 6'h00;
        dith_cnt_reg <= dith_cnt_reg + 5'h01;
        if (div_cnt_reg >= (10'h001 << div_eff(val_reg[11:8])) - 10'h001) begin
          div_cnt_reg <= 10'h000;
          osc_tick_reg <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 10'h001;
        end
      end else begin
        ring_cnt_reg <= ring_cnt_reg + 6'h01;
      end
    end
  end

  // ----------------------------------------
  // loop filter
  // ----------------------------------------
  logic [8:0] tgt; // 4 times N internal periods per interval
  logic [9:0] err; // absolute period-count error
  logic fast; // more internal periods than target
  logic [11:0] step; // correction size
  logic [11:0] up_val; // saturating increment
  logic [11:0] dn_val; // saturating decrement
  logic [12:0] sum; // unsaturated increment
  logic [19:0] err_x100; // error scaled by one hundred
  logic [19:0] tgt_coarse; // target scaled by coarse percent
  logic [19:0] tgt_stable; // target scaled by stable percent
  always_comb begin
    tgt = {mult_reg, 2'b00};
    fast = ({1'b0, icnt_reg} > {2'b00, tgt} + 11'h000);
    err = fast ? (icnt_reg - {1'b0, tgt}) : ({1'b0, tgt} - icnt_reg);
    // twenty bits keep a large count error times one hundred from wrapping
    err_x100 = {10'h000, err} * 20'h00064;
    tgt_coarse = {11'h000, tgt} * 20'(`COARSE_PCT);
    tgt_stable = {11'h000, tgt} * 20'(`STABLE_PCT);
    step = (err_x100 > tgt_coarse) ? `COARSE_STEP : `FINE_STEP;
    // divider moves only through carry out of the stage field
    sum = {1'b0, val_reg} + {1'b0, step};
    up_val = (sum[12:8] > {1'b0, `DIV_MAX_CODE}) ? {`DIV_MAX_CODE, 8'hFF}
             : sum[11:0];
    dn_val = (val_reg < step) ? 12'h000 : val_reg - step;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lf_state_reg <= LF_ALIGN; // resettle after reset
      ref_cnt_reg <= 2'h0;
      icnt_reg <= 10'h000;
      val_reg <= {`RST_DIV, `RST_STG};
      int_stable_reg <= 1'b0;
    end else if (i_ce) begin
      if (restart_req) begin
        int_stable_reg <= 1'b0;
        lf_state_reg <= int_on_reg ? LF_ALIGN : LF_HALT;
        ref_cnt_reg <= 2'h0;
        icnt_reg <= 10'h000;
      end
      if (!int_on_reg && wr && (i_wb_adr == `OFS_DIV)) val_reg[11:8] <= wd[3:0];
      if (!int_on_reg && wr && (i_wb_adr == `OFS_STG)) val_reg[7:0] <= wd;
      if (!restart_req) begin
        unique case (lf_state_reg)
          LF_HALT: lf_state_reg <= LF_ALIGN;
          LF_ALIGN: begin
            // interval starts on a reference edge
            if (i_ref_tick) lf_state_reg <= LF_MEASURE;
          end
          LF_MEASURE: begin
            if (osc_tick_reg && icnt_reg != 10'h3FF) icnt_reg <= icnt_reg + 10'h001;
            if (i_ref_tick) begin
              ref_cnt_reg <= ref_cnt_reg + 2'h1;
              if (ref_cnt_reg == `REF_PER_CORR) begin
                icnt_reg <= 10'h000;
                // fast clock wants a longer period and the reverse
                if (icnt_reg != {1'b0, tgt}) val_reg <= fast ? up_val : dn_val;
                int_stable_reg <= (err_x100 <= tgt_stable);
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_internal_clock <= 1'b0;
      o_clock_select <= 1'b0;
      o_internal_stable <= 1'b0;
      o_monitor_irq <= 1'b0;
      o_divider_field <= 4'h0;
      o_stage_field <= 8'h00;
    end else if (i_ce) begin
      o_internal_clock <= osc_tick_reg;
      o_clock_select <= select_reg;
      o_internal_stable <= int_stable_reg;
      o_monitor_irq <= mon_fail_reg & mon_irq_en_reg;
      o_divider_field <= val_reg[11:8];
      o_stage_field <= val_reg[7:0];
    end
  end
  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_SELECT_GUARD: assert property (
    i_ce && wr_ctrl && wd[`BIT_SELECT] && !select_reg && !ext_stable_reg && !mon_en_reg
    |=> !select_reg) else $error("select moved to an unstable source");
  AST_MON_EN_GUARD: assert property (
    i_ce && !mon_en_reg && !(int_stable_reg && ext_stable_reg) |=> !mon_en_reg)
    else $error("monitor enabled without both clocks stable");
  AST_IRQ_EN_GUARD: assert property (
    i_ce && !mon_en_reg && !mon_irq_en_reg |=> !mon_irq_en_reg)
    else $error("monitor irq enable set before monitor enable");
  AST_FAILOVER: assert property (
    i_ce && mon_en_reg && !select_reg && ioff && !eoff |=> select_reg ##1 o_clock_select)
    else $error("no switch away from dead internal clock");
  AST_FAIL_SET: assert property (
    i_ce && mon_en_reg && (ioff || eoff) |=> mon_fail_reg)
    else $error("fail flag not set on dead source");
  AST_FAIL_NEEDS_READ: assert property (
    i_ce && mon_fail_reg && !fail_armed_reg |=> mon_fail_reg)
    else $error("fail flag cleared without prior read");
  AST_DIV_RANGE: assert property (
    i_ce && val_reg[11:8] <= `DIV_MAX_CODE && !(wr && (i_wb_adr == `OFS_DIV))
    |=> val_reg[11:8] <= `DIV_MAX_CODE) else $error("divider field beyond nine");
  AST_RESETTLE: assert property (
    i_ce && wr_mult && (wd[6:0] != mult_reg) |=> !int_stable_reg ##1 !o_internal_stable)
    else $error("stable flag kept across factor change");

endmodule
`default_nettype wire

/* File: dv/test_dco_loop_and_clock_monitor.sv */
// self-checking bench for the oscillator loop and clock monitor
`timescale 1ns/1ps
`default_nettype none
`include "dco_loop_map.svh"
module test_dco_loop_and_clock_monitor;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic i_clk, i_rst_n, i_ce, i_wb_cyc, i_wb_stb, i_wb_we;
  logic [7:0] i_wb_adr;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, q;
  logic o_wb_ack, i_ref_tick, i_ext_clk_tick, i_ext_stable;
  logic o_internal_clock, o_clock_select, o_internal_stable, o_monitor_irq;
  logic [3:0] o_divider_field;
  logic [7:0] o_stage_field;
  int error_cnt = 0; // mismatches seen
  int num_checks = 0; // comparisons made
  int ref_per = 0; // reference period in cycles, 0 stops it
  int ref_cnt = 0;
  int ext_cnt = 0;
  logic ext_run = 1'b0; // external oscillator activity on/off
  logic frz_last; // oscillator output when the enable fell
  int cyc;
  // one oscillator setting and the cycles that nper periods should take
  typedef struct {logic [3:0] dv; logic [7:0] st; int nper; int total;} row_type;
  row_type rows [7] = '{'{4'h0, 8'h00, 32, 544}, '{4'h0, 8'h61, 32, 738},
    '{4'h0, 8'hF0, 32, 1040}, '{4'h1, 8'h00, 4, 136}, '{4'h2, 8'h20, 4, 304},
    '{4'h9, 8'h00, 1, 8704}, '{4'hF, 8'h00, 1, 8704}};
  // reset values; the last address is unmapped and must read zero
  logic [7:0] radr [6] = '{`OFS_CTRL, `OFS_MULT, `OFS_TRIM, `OFS_DIV, `OFS_STG, 8'h14};
  logic [7:0] rval [6] = '{8'h08, 8'h15, 8'h80, 8'h00, 8'h00, 8'h00};

  // short monitor timeout so a dead source shows within a few hundred cycles
  dco_loop_and_clock_monitor #(.MON_TIMEOUT_CYC(200)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
    .i_ref_tick(i_ref_tick), .i_ext_clk_tick(i_ext_clk_tick),
    .i_ext_stable(i_ext_stable), .o_internal_clock(o_internal_clock),
    .o_clock_select(o_clock_select), .o_internal_stable(o_internal_stable),
    .o_monitor_irq(o_monitor_irq), .o_divider_field(o_divider_field),
    .o_stage_field(o_stage_field));

  // ----------------------------------------
  // clock, reference and external activity
  // ----------------------------------------
  // 40 MHz system clock
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // reference pulse every ref_per cycles, external pulse every 8 cycles
  always @(posedge i_clk) begin
    ref_cnt <= (ref_per == 0 || ref_cnt + 1 >= ref_per) ? 0 : ref_cnt + 1;
    i_ref_tick <= (ref_per != 0 && ref_cnt + 1 >= ref_per);
    ext_cnt <= (ext_cnt + 1) % 8;
    i_ext_clk_tick <= ext_run && (ext_cnt == 0);
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // compare and count
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask
  // classic single wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_sel <= 4'hF;
    i_wb_adr <= a;
    i_wb_dat <= {24'h000000, d};
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    q = o_wb_dat;
    if (n >= 50) check("ack", 32'h1, 32'h0);
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  // cycles taken by nper internal periods, after skipping one period
  task automatic measure(input int nper, output int c);
    int n;
    repeat (2) begin
      @(posedge i_clk);
      n = 0;
      while (o_internal_clock !== 1'b1 && n < 20000) begin
        @(posedge i_clk);
        n++;
      end
    end
    c = 0;
    for (int k = 0; k < nper; k++) begin
      do begin
        @(posedge i_clk);
        c++;
      end while (o_internal_clock !== 1'b1 && c < 300000);
    end
  endtask
  // counts, verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run of some 70000 cycles
  initial begin
    repeat (90000) @(posedge i_clk);
    error_cnt++;
    complete_run();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {i_ce, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we} = 5'b10000;
    {i_wb_adr, i_wb_sel, i_wb_dat, i_ext_stable} = '0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    i_wb_sel <= 4'hF;
    // run on the external clock so the internal one may be stopped
    i_ext_stable <= 1'b1;
    ext_run <= 1'b1;
    wb(1, `OFS_CTRL, 8'h0A);
    wb(1, `OFS_CTRL, 8'h1A);
    // table: start point written while stopped, then period at the output
    foreach (rows[i]) begin
      wb(1, `OFS_CTRL, 8'h12);
      wb(1, `OFS_DIV, {4'h0, rows[i].dv});
      wb(1, `OFS_STG, rows[i].st);
      wb(1, `OFS_CTRL, 8'h1A);
      check("stage", {24'h0, rows[i].st}, {24'h0, o_stage_field});
      if (rows[i].dv <= 4'h9) check("div", {28'h0, rows[i].dv}, {28'h0, o_divider_field});
      measure(rows[i].nper, cyc);
      check("period", rows[i].total, cyc);
    end
    // second reset mid-run
    ext_run <= 1'b0;
    i_ext_stable <= 1'b0;
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    check("select in reset", 32'h0, {31'h0, o_clock_select});
    check("loop in reset", 32'h0, {20'h0, o_divider_field, o_stage_field});
    i_rst_n <= 1'b1;
    // enable low freezes the running oscillator, so its output shows no edge
    repeat (20) @(posedge i_clk);
    i_ce <= 1'b0;
    @(posedge i_clk);
    frz_last = o_internal_clock;
    cyc = 0;
    repeat (60) begin
      @(posedge i_clk);
      if (o_internal_clock !== frz_last) cyc++;
    end
    i_ce <= 1'b1;
    check("frozen by enable", 32'h0, cyc);
    foreach (radr[i]) begin
      wb(0, radr[i], 8'h00);
      check("reset value", {24'h0, rval[i]}, q);
    end
    // select, monitor and irq enable all refused with external off
    wb(1, `OFS_CTRL, 8'hB8);
    wb(0, `OFS_CTRL, 8'h00);
    check("guarded ctrl", 32'h08, q);
    // too fast: coarse step up at the end of the first interval
    ref_per <= 714;
    repeat (5 * 714 + 20) @(posedge i_clk);
    check("coarse up", 32'h020, {20'h0, o_divider_field, o_stage_field});
    // too slow: step down, then held at the bottom end
    ref_per <= 100;
    repeat (1500) @(posedge i_clk);
    check("saturate low", 32'h000, {20'h0, o_divider_field, o_stage_field});
    // reference matching N pulses of 17 cycles: loop settles
    ref_per <= 357;
    repeat (16 * 357) @(posedge i_clk);
    check("stable", 32'h1, {31'h0, o_internal_stable});
    // both clocks up, monitor before irq enable, select external in the irq enable write
    i_ext_stable <= 1'b1;
    ext_run <= 1'b1;
    wb(1, `OFS_CTRL, 8'h0A);
    wb(1, `OFS_CTRL, 8'h2A);
    wb(1, `OFS_CTRL, 8'hBA);
    wb(0, `OFS_CTRL, 8'h00);
    check("monitor on", 32'hBF, q);
    // external dies: flag and automatic return to internal
    ext_run <= 1'b0;
    repeat (260) @(posedge i_clk);
    check("fallback", 32'h0, {31'h0, o_clock_select});
    check("irq", 32'h1, {31'h0, o_monitor_irq});
    ext_run <= 1'b1;
    repeat (20) @(posedge i_clk);
    // a whole-byte write without the arming read leaves the flag set
    wb(1, `OFS_CTRL, 8'hAA);
    check("flag kept", 32'h1, {31'h0, o_monitor_irq});
    // handler reads the control register first, which arms the clear
    wb(0, `OFS_CTRL, 8'h00);
    check("flag and select", 32'h40, q & 32'h50);
    wb(1, `OFS_CTRL, 8'hAA);
    // flag falls at the ack edge, its registered copy one edge later
    repeat (2) @(posedge i_clk);
    check("flag cleared", 32'h0, {31'h0, o_monitor_irq});
    // new factor with the monitor off first; stable drops, enable refused
    wb(1, `OFS_CTRL, 8'h0A);
    wb(1, `OFS_MULT, 8'h2A);
    repeat (2) @(posedge i_clk);
    check("stable drop", 32'h0, {31'h0, o_internal_stable});
    wb(1, `OFS_CTRL, 8'h2A);
    wb(0, `OFS_CTRL, 8'h00);
    check("monitor refused", 32'h0, q & 32'h20);
    complete_run();
  end
endmodule
`default_nettype wire
